/* File: rtl/gdfh_pkg.sv */
// constants shared by the gate driver fault handler
// assumes a 100 MHz core clock; no register bus, all settings are ports
package gdfh_pkg;
   // ---------------------------------------------------------------
   // overcurrent policy encoding
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      gdfh_oc_limit   = 2'h0,
      gdfh_oc_latch   = 2'h1,
      gdfh_oc_report  = 2'h2,
      gdfh_oc_off     = 2'h3
   } gdfh_oc_policy_t;

   // ---------------------------------------------------------------
   // warning pin source selection
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      gdfh_warn_both  = 2'h0,
      gdfh_warn_otw   = 2'h1,
      gdfh_warn_oc    = 2'h2
   } gdfh_warn_sel_t;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 10_000;
   localparam int REPORT_TIME_US = 64;
   localparam int REPORT_CYCLES =
      (REPORT_TIME_US * 1_000_000) / CLK_PERIOD_PS;
   localparam int TIMER_W = 13;
   localparam logic [TIMER_W-1:0] TIMER_LOAD =
      TIMER_W'(REPORT_CYCLES - 1);
   localparam logic [TIMER_W-1:0] TIMER_ZERO = 13'h0000;

   // ---------------------------------------------------------------
   // geometry and reset values
   // ---------------------------------------------------------------
   localparam int N_PHASE = 3;
   localparam int N_SW = 6;
   localparam logic [5:0] SW_NONE = 6'h00;
endpackage : gdfh_pkg

/* File: rtl/gdfh_timer.sv */
// restartable 64 us down counter for report and off-time windows
// assumes the core clock of the package; restart wins over expiry
`timescale 1ns/10ps
`default_nettype none
module gdfh_timer (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic restart_i,
   input wire logic cancel_i,
   output logic running_o
);
   logic [gdfh_pkg::TIMER_W-1:0] count;

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         count <= gdfh_pkg::TIMER_ZERO;
         running_o <= 1'b0;
      end else if (restart_i) begin
         count <= gdfh_pkg::TIMER_LOAD;
         running_o <= 1'b1;
      end else if (cancel_i || count == gdfh_pkg::TIMER_ZERO) begin
         running_o <= 1'b0;
      end else begin
         count <= count - 1'b1;
      end
   end
endmodule : gdfh_timer
`default_nettype wire

/* File: rtl/gdfh_fault_handler.sv */
// fault protection and reporting for a three-phase gate driver
// assumes comparator, supply and pwm inputs are synchronous to clock_i
// and that gate enable has already been decoded into quick/full resets
`timescale 1ns/10ps
`default_nettype none
module gdfh_fault_handler (
   input wire logic clock_i,
   input wire logic srst_i,
   // gate enable decoded events
   input wire logic enable_i,
   input wire logic quick_reset_i,
   input wire logic full_reset_i,
   // command side
   input wire logic cmd_write_i,
   input wire logic [1:0] policy_wdata_i,
   input wire logic [1:0] warn_sel_wdata_i,
   input wire logic off_time_wdata_i,
   input wire logic gate_reset_wdata_i,
   input wire logic read_done_i,
   // sensing
   input wire logic [5:0] oc_detect_i,
   input wire logic main_supply_undervoltage_i,
   input wire logic gate_supply_undervoltage_i,
   input wire logic gate_supply_overvoltage_i,
   input wire logic digital_supply_undervoltage_i,
   input wire logic overtemp_warning_i,
   input wire logic overtemp_gate_shutdown_i,
   input wire logic [2:0] pwm_cycle_i,
   input wire logic [5:0] gate_cmd_i,
   // gate side: bits 0,2,4 high gates, 1,3,5 low gates
   output logic [5:0] gate_out_o,
   output logic charge_pump_en_o,
   output logic cmd_ignored_o,
   // open-drain indicator pins, enable high pulls low
   output logic fault_indicator_n_o,
   output logic fault_indicator_n_oe_o,
   output logic warning_indicator_n_o,
   output logic warning_indicator_n_oe_o,
   // status
   output logic [1:0] overcurrent_policy_o,
   output logic [1:0] warn_sel_o,
   output logic per_cycle_limit_o,
   output logic status_fault_o,
   output logic [5:0] status_oc_o,
   output logic status_main_uv_o,
   output logic status_gate_uv_o,
   output logic status_gate_ov_o,
   output logic status_otw_o,
   output logic status_otsd_o
);
   gdfh_pkg::gdfh_oc_policy_t policy;
   gdfh_pkg::gdfh_warn_sel_t warn_sel;
   logic off_time;
   logic [5:0] oc_hit;
   logic [5:0] sw_limited;
   logic [2:0] phase_latched;
   logic oc_latched;
   logic ov_latched;
   logic otsd_latched;
   logic soft_reset;
   logic digital_supply_uv_q;
   logic status_clear;
   logic timer_running;
   logic timer_restart;
   logic timer_cancel;
   logic ready;
   logic next_fault;
   logic next_warn;
   logic oc_warn;
   logic [5:0] next_gate;
   logic [5:0] phase_mask;

   // ---------------------------------------------------------------
   // configuration
   // ---------------------------------------------------------------
   // defaults restored under main undervoltage, kept under overtemp
   always_ff @(posedge clock_i) begin
      if (srst_i || full_reset_i || main_supply_undervoltage_i) begin
         policy <= gdfh_pkg::gdfh_oc_limit;
         warn_sel <= gdfh_pkg::gdfh_warn_both;
         off_time <= 1'b0;
      end else if (cmd_write_i) begin
         policy <= gdfh_pkg::gdfh_oc_policy_t'(policy_wdata_i);
         if (warn_sel_wdata_i != 2'h3) begin
            warn_sel <= gdfh_pkg::gdfh_warn_sel_t'(warn_sel_wdata_i);
         end
         off_time <= off_time_wdata_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cmd_ignored_o <= 1'b0;
      end else begin
         cmd_ignored_o <= main_supply_undervoltage_i;
      end
   end

   assign soft_reset = quick_reset_i || full_reset_i ||
      (cmd_write_i && gate_reset_wdata_i && !main_supply_undervoltage_i);

   // ---------------------------------------------------------------
   // overcurrent qualification
   // ---------------------------------------------------------------
   // a disabled policy blanks the detections before anything sees them
   assign oc_hit = (policy == gdfh_pkg::gdfh_oc_off) ?
      gdfh_pkg::SW_NONE : oc_detect_i;

   // ---------------------------------------------------------------
   // latched faults
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         oc_latched <= 1'b0;
         phase_latched <= 3'h0;
      end else if (policy == gdfh_pkg::gdfh_oc_latch && |oc_hit) begin
         oc_latched <= 1'b1;
         phase_latched <= phase_latched | {oc_hit[5] | oc_hit[4],
            oc_hit[3] | oc_hit[2], oc_hit[1] | oc_hit[0]};
      end else if (soft_reset) begin
         oc_latched <= 1'b0;
         phase_latched <= 3'h0;
      end
   end

   // only a full enable reset clears overvoltage
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ov_latched <= 1'b0;
      end else if (gate_supply_overvoltage_i) begin
         ov_latched <= 1'b1;
      end else if (full_reset_i) begin
         ov_latched <= 1'b0;
      end
   end

   // reset only takes once cool: the detector still high keeps it set
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         otsd_latched <= 1'b0;
      end else if (overtemp_gate_shutdown_i) begin
         otsd_latched <= 1'b1;
      end else if (soft_reset) begin
         otsd_latched <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // current limit and report timing
   // ---------------------------------------------------------------
   assign timer_restart = |oc_hit &&
      (policy == gdfh_pkg::gdfh_oc_limit ||
       policy == gdfh_pkg::gdfh_oc_report);
   assign timer_cancel = policy == gdfh_pkg::gdfh_oc_limit && !off_time &&
      (sw_limited == gdfh_pkg::SW_NONE);

   gdfh_timer u_timer (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .restart_i(timer_restart),
      .cancel_i(timer_cancel),
      .running_o(timer_running)
   );

   // offending switch off until its pwm cycle, or until the window ends
   generate
      for (genvar s = 0; s < gdfh_pkg::N_SW; s++) begin : g_sw
         always_ff @(posedge clock_i) begin
            if (srst_i || policy != gdfh_pkg::gdfh_oc_limit) begin
               sw_limited[s] <= 1'b0;
            end else if (oc_hit[s]) begin
               sw_limited[s] <= 1'b1;
            end else if (pwm_cycle_i[s/2] ||
                         (off_time && !timer_running)) begin
               sw_limited[s] <= 1'b0;
            end
         end
      end
   endgenerate

   assign oc_warn = timer_running &&
      (policy == gdfh_pkg::gdfh_oc_report ||
       policy == gdfh_pkg::gdfh_oc_limit);

   // ---------------------------------------------------------------
   // status bits
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         digital_supply_uv_q <= 1'b0;
      end else begin
         digital_supply_uv_q <= digital_supply_undervoltage_i;
      end
   end

   assign status_clear = (digital_supply_uv_q && !digital_supply_undervoltage_i) ||
      soft_reset;

   // new event wins over a completing read
   always_ff @(posedge clock_i) begin
      if (srst_i || status_clear) begin
         status_oc_o <= gdfh_pkg::SW_NONE;
      end else if (|oc_hit) begin
         status_oc_o <= (read_done_i ? gdfh_pkg::SW_NONE : status_oc_o) |
            oc_hit;
      end else if (read_done_i) begin
         status_oc_o <= gdfh_pkg::SW_NONE;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         status_fault_o <= 1'b0;
         status_main_uv_o <= 1'b0;
         status_gate_uv_o <= 1'b0;
         status_gate_ov_o <= 1'b0;
         status_otw_o <= 1'b0;
         status_otsd_o <= 1'b0;
      end else begin
         // digital undervoltage stays off the status bit
         status_fault_o <= oc_latched || ov_latched || otsd_latched ||
            main_supply_undervoltage_i || gate_supply_undervoltage_i;
         status_main_uv_o <= main_supply_undervoltage_i;
         status_gate_uv_o <= gate_supply_undervoltage_i;
         status_gate_ov_o <= ov_latched;
         status_otw_o <= overtemp_warning_i;
         status_otsd_o <= otsd_latched;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         overcurrent_policy_o <= 2'h0;
         warn_sel_o <= 2'h0;
         per_cycle_limit_o <= 1'b1;
      end else begin
         overcurrent_policy_o <= policy;
         warn_sel_o <= warn_sel;
         per_cycle_limit_o <= !off_time;
      end
   end

   // ---------------------------------------------------------------
   // readiness
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (srst_i || !enable_i) begin
         ready <= 1'b0;
      end else begin
         ready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // gate outputs and indicators
   // ---------------------------------------------------------------
   // digital undervoltage is only on the pin, never in status
   assign next_fault = oc_latched || ov_latched || otsd_latched ||
      main_supply_undervoltage_i || gate_supply_undervoltage_i ||
      digital_supply_undervoltage_i;

   always_comb begin
      next_warn = otsd_latched;
      case (warn_sel)
         gdfh_pkg::gdfh_warn_otw: next_warn = next_warn ||
            overtemp_warning_i;
         gdfh_pkg::gdfh_warn_oc: next_warn = next_warn || oc_warn;
         default: next_warn = next_warn || oc_warn ||
            overtemp_warning_i;
      endcase
   end

   generate
      for (genvar p = 0; p < gdfh_pkg::N_PHASE; p++) begin : g_ph
         assign phase_mask[2*p+1:2*p] = {2{phase_latched[p]}};
      end
   endgenerate

   // shutdown dominates everything; a hit in the same cycle is caught too
   always_comb begin
      next_gate = gate_cmd_i & ~phase_mask & ~sw_limited & ~oc_hit_mask();
      if (!ready || main_supply_undervoltage_i ||
          gate_supply_undervoltage_i || digital_supply_undervoltage_i ||
          ov_latched || otsd_latched) begin
         next_gate = gdfh_pkg::SW_NONE;
      end
   end

   function automatic logic [5:0] oc_hit_mask();
      logic [5:0] m;
      m = gdfh_pkg::SW_NONE;
      if (policy == gdfh_pkg::gdfh_oc_latch) begin
         m = {{2{oc_hit[5] | oc_hit[4]}}, {2{oc_hit[3] | oc_hit[2]}},
            {2{oc_hit[1] | oc_hit[0]}}};
      end else if (policy == gdfh_pkg::gdfh_oc_limit) begin
         m = oc_hit;
      end
      return m;
   endfunction : oc_hit_mask

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         gate_out_o <= gdfh_pkg::SW_NONE;
         charge_pump_en_o <= 1'b0;
         fault_indicator_n_o <= 1'b0;
         fault_indicator_n_oe_o <= 1'b1;
         warning_indicator_n_o <= 1'b0;
         warning_indicator_n_oe_o <= 1'b0;
      end else begin
         gate_out_o <= next_gate;
         charge_pump_en_o <= enable_i && !ov_latched && !otsd_latched;
         fault_indicator_n_o <= 1'b0;
         fault_indicator_n_oe_o <= next_fault || !ready;
         warning_indicator_n_o <= 1'b0;
         warning_indicator_n_oe_o <= next_warn;
      end
   end
endmodule : gdfh_fault_handler
`default_nettype wire

/* File: tb/gdfh_fault_handler_chk.sv */
// port-level assertions for the gate driver fault handler
// bound to every gdfh_fault_handler instance; one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module gdfh_chk (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic quick_reset_i,
   input wire logic full_reset_i,
   input wire logic cmd_write_i,
   input wire logic gate_reset_wdata_i,
   input wire logic [5:0] oc_detect_i,
   input wire logic main_supply_undervoltage_i,
   input wire logic gate_supply_undervoltage_i,
   input wire logic gate_supply_overvoltage_i,
   input wire logic digital_supply_undervoltage_i,
   input wire logic [5:0] gate_out_o,
   input wire logic charge_pump_en_o,
   input wire logic cmd_ignored_o,
   input wire logic fault_indicator_n_oe_o,
   input wire logic warning_indicator_n_oe_o,
   input wire logic [1:0] overcurrent_policy_o,
   input wire logic per_cycle_limit_o,
   input wire logic [5:0] status_oc_o,
   input wire logic status_gate_ov_o,
   input wire logic status_otsd_o
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   logic duv_q;
   logic cfg_q;
   logic calm;
   logic uv;
   // policy readback trails the live policy by one cycle after a change
   always_ff @(posedge clock_i) begin
      duv_q <= digital_supply_undervoltage_i;
      cfg_q <= cmd_write_i || full_reset_i || main_supply_undervoltage_i;
   end
   // digital undervoltage recovery wipes status, so skip its edges too
   assign calm = !quick_reset_i && !full_reset_i
      && !(cmd_write_i && gate_reset_wdata_i)
      && !digital_supply_undervoltage_i && !duv_q;
   assign uv = main_supply_undervoltage_i || gate_supply_undervoltage_i;

   a_latch_bridge_off: assert property (
      overcurrent_policy_o == gdfh_pkg::gdfh_oc_latch
      && oc_detect_i[3:2] != 2'h0 && calm && !cfg_q
      |=> gate_out_o[3:2] == 2'h0)
      else $error("latched bridge not forced off");
   a_oc_bit_set: assert property (
      overcurrent_policy_o != gdfh_pkg::gdfh_oc_off && oc_detect_i != 6'h00
      && calm && !cfg_q && !main_supply_undervoltage_i
      |=> (status_oc_o & $past(oc_detect_i)) == $past(oc_detect_i))
      else $error("switch overcurrent bit not set");
   a_oc_off_silent: assert property (
      overcurrent_policy_o == gdfh_pkg::gdfh_oc_off && status_oc_o == 6'h00
      && !cmd_write_i && !full_reset_i && !main_supply_undervoltage_i
      && !cfg_q
      |=> status_oc_o == 6'h00)
      else $error("disabled policy reported overcurrent");
   a_uv_gates_low: assert property (uv |=> gate_out_o == 6'h00)
      else $error("gates driven in undervoltage");
   a_uv_cmd_default: assert property (
      main_supply_undervoltage_i |=> cmd_ignored_o
      ##1 (overcurrent_policy_o == 2'h0 && per_cycle_limit_o))
      else $error("settings kept in main undervoltage");
   a_uv_fault_pin: assert property (
      uv |-> ##[1:2] fault_indicator_n_oe_o)
      else $error("undervoltage not on fault pin");
   a_ov_sticky: assert property (
      status_gate_ov_o && !full_reset_i && !digital_supply_undervoltage_i
      && !duv_q && !$past(full_reset_i) |=> status_gate_ov_o)
      else $error("overvoltage cleared by soft reset");
   a_ov_shutdown: assert property (
      (gate_supply_overvoltage_i && !full_reset_i) [*2]
      |=> !charge_pump_en_o && gate_out_o == 6'h00)
      else $error("overvoltage left pump or gates on");
   a_otsd_holds: assert property (
      status_otsd_o && calm && $past(calm) |=> status_otsd_o)
      else $error("thermal shutdown recovered alone");

   c_latch_trip: cover property (overcurrent_policy_o == 2'h1
      && oc_detect_i != 6'h00);
   c_warn_pulse: cover property ($fell(warning_indicator_n_oe_o));
   c_ov_trip: cover property (status_gate_ov_o && !charge_pump_en_o);
endmodule : gdfh_chk

bind gdfh_fault_handler gdfh_chk u_chk (.*);
`default_nettype wire

/* File: tb/gdfh_pin_model.sv */
// host side of the two open-drain indicator pins
// assumes pull-ups to the host supply on both lines
`timescale 1ns/10ps
`default_nettype none
module gdfh_pin_model (
   input wire logic fault_oe_i,
   input wire logic fault_drv_i,
   input wire logic warn_oe_i,
   input wire logic warn_drv_i,
   output logic fault_pin_o,
   output logic warn_pin_o
);
   // released lines float up to the pull-up level, never hold old data
   assign fault_pin_o = fault_oe_i ? fault_drv_i : 1'b1;
   assign warn_pin_o = warn_oe_i ? warn_drv_i : 1'b1;
endmodule : gdfh_pin_model
`default_nettype wire

/* File: tb/test_gate_driver_fault_handler.sv */
// self-checking bench for the gate driver fault handler
// assumes the pin model for pull-ups and the bound checker
`timescale 1ns/10ps
`default_nettype none
module test_gate_driver_fault_handler;
   logic clock_i = 1'b0, srst_i = 1'b1, enable_i = 1'b1;
   logic quick_reset_i = 1'b0, full_reset_i = 1'b0, cmd_write_i = 1'b0;
   logic [1:0] policy_wdata_i = 2'h0, warn_sel_wdata_i = 2'h0;
   logic off_time_wdata_i = 1'b0, gate_reset_wdata_i = 1'b0;
   logic read_done_i = 1'b0, overtemp_warning_i = 1'b0;
   logic [5:0] oc_detect_i = 6'h00, gate_cmd_i = 6'h3f;
   logic main_supply_undervoltage_i = 1'b0;
   logic gate_supply_undervoltage_i = 1'b0;
   logic gate_supply_overvoltage_i = 1'b0;
   logic digital_supply_undervoltage_i = 1'b0;
   logic overtemp_gate_shutdown_i = 1'b0;
   logic [2:0] pwm_cycle_i = 3'h0;
   logic [5:0] gate_out_o, status_oc_o;
   logic charge_pump_en_o, cmd_ignored_o, fault_indicator_n_o;
   logic fault_indicator_n_oe_o, warning_indicator_n_o;
   logic warning_indicator_n_oe_o, per_cycle_limit_o, status_fault_o;
   logic [1:0] overcurrent_policy_o, warn_sel_o;
   logic status_main_uv_o, status_gate_uv_o, status_gate_ov_o;
   logic status_otw_o, status_otsd_o, fault_pin, warn_pin;
   int n_errors = 0, checks_done = 0, cycles = 0, w;

   gdfh_fault_handler DUT (.*);
   gdfh_pin_model u_host (
      .fault_oe_i(fault_indicator_n_oe_o),
      .fault_drv_i(fault_indicator_n_o),
      .warn_oe_i(warning_indicator_n_oe_o),
      .warn_drv_i(warning_indicator_n_o),
      .fault_pin_o(fault_pin),
      .warn_pin_o(warn_pin)
   );

   always #5 clock_i = ~clock_i;

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask : cyc

   task automatic ck(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : ck

   task automatic cmd(input logic [1:0] pol, input logic [1:0] sel,
                      input logic ofs, input logic rst);
      cmd_write_i = 1'b1;
      policy_wdata_i = pol;
      warn_sel_wdata_i = sel;
      off_time_wdata_i = ofs;
      gate_reset_wdata_i = rst;
      cyc(1);
      cmd_write_i = 1'b0;
      gate_reset_wdata_i = 1'b0;
      cyc(3);
   endtask : cmd

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   // cut a hang short; whole run needs about 13000 cycles
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   // ---------------------------------------------------------------
   // stimulus
   // ---------------------------------------------------------------
   initial begin
      cyc(6);
      srst_i = 1'b0;
      cyc(4);
      ck(fault_pin, 1'b1);
      for (w = 0; w < 2; w++) begin
         cmd(gdfh_pkg::gdfh_oc_latch, 2'h0, 1'b0, 1'b0);
         oc_detect_i = 6'h04;
         cyc(1);
         oc_detect_i = 6'h00;
         cyc(2);
         ck({fault_pin, status_fault_o, gate_out_o}, 8'h73);
         ck(status_oc_o, 6'h04);
         read_done_i = 1'b1;
         cyc(1);
         read_done_i = 1'b0;
         cyc(2);
         ck({status_oc_o, fault_pin, status_fault_o}, 8'h01);
         quick_reset_i = (w == 0);
         cmd(2'h1, 2'h0, 1'b0, w == 1);
         quick_reset_i = 1'b0;
         cyc(2);
         ck({fault_pin, status_fault_o, gate_out_o}, 8'hbf);
      end
      cmd(gdfh_pkg::gdfh_oc_report, 2'h0, 1'b0, 1'b0);
      oc_detect_i = 6'h02;
      cyc(1);
      oc_detect_i = 6'h00;
      for (w = 0; w < 9 && warning_indicator_n_oe_o !== 1'b1; w++) cyc(1);
      ck({warn_pin, fault_pin, gate_out_o, status_oc_o}, 14'h1fc2);
      for (w = 0; w < 9000 && warning_indicator_n_oe_o === 1'b1; w++) cyc(1);
      ck(w, gdfh_pkg::REPORT_CYCLES);
      cmd(gdfh_pkg::gdfh_oc_off, 2'h0, 1'b0, 1'b0);
      oc_detect_i = 6'h3f;
      cyc(3);
      ck({warn_pin, fault_pin, gate_out_o}, 8'hff);
      ck(status_oc_o, 6'h02);
      oc_detect_i = 6'h00;
      cmd(gdfh_pkg::gdfh_oc_limit, 2'h0, 1'b0, 1'b0);
      oc_detect_i = 6'h01;
      cyc(1);
      oc_detect_i = 6'h00;
      cyc(2);
      ck({warn_pin, fault_pin, gate_out_o}, 8'h7e);
      pwm_cycle_i = 3'h1;
      cyc(1);
      pwm_cycle_i = 3'h0;
      cyc(3);
      ck({warn_pin, gate_out_o}, 7'h7f);
      cmd(gdfh_pkg::gdfh_oc_limit, 2'h0, 1'b1, 1'b0);
      oc_detect_i = 6'h04;
      cyc(1);
      oc_detect_i = 6'h00;
      cyc(3);
      ck({per_cycle_limit_o, warn_pin, gate_out_o}, 8'h3b);
      cyc(6402);
      ck({warn_pin, gate_out_o}, 7'h7f);
      overtemp_warning_i = 1'b1;
      for (w = 0; w < 3; w++) begin
         cmd(2'h0, w[1:0], 1'b0, 1'b0);
         ck({warn_pin, fault_pin, status_otw_o}, {w[1], 2'h3});
      end
      overtemp_warning_i = 1'b0;
      cmd(gdfh_pkg::gdfh_oc_latch, 2'h1, 1'b1, 1'b0);
      for (w = 0; w < 2; w++) begin
         main_supply_undervoltage_i = (w == 0);
         gate_supply_undervoltage_i = (w == 1);
         cyc(2);
         cmd(2'h2, 2'h2, 1'b0, 1'b0);
         ck({gate_out_o, fault_pin, warn_pin, status_main_uv_o,
             status_gate_uv_o}, {8'h01, w == 0, w == 1});
         if (w == 0) ck({cmd_ignored_o, overcurrent_policy_o, warn_sel_o,
                         per_cycle_limit_o}, 6'h21);
         main_supply_undervoltage_i = 1'b0;
         gate_supply_undervoltage_i = 1'b0;
         cyc(3);
         ck({gate_out_o, fault_pin}, 7'h7f);
      end
      cmd(gdfh_pkg::gdfh_oc_report, 2'h0, 1'b0, 1'b0);
      gate_supply_overvoltage_i = 1'b1;
      cyc(2);
      gate_supply_overvoltage_i = 1'b0;
      cyc(2);
      ck({charge_pump_en_o, gate_out_o, fault_pin, warn_pin,
          status_gate_ov_o}, 10'h003);
      quick_reset_i = 1'b1;
      cmd(2'h2, 2'h0, 1'b0, 1'b1);
      quick_reset_i = 1'b0;
      cyc(2);
      ck({charge_pump_en_o, status_gate_ov_o, fault_pin}, 3'h2);
      full_reset_i = 1'b1;
      cyc(1);
      full_reset_i = 1'b0;
      cyc(4);
      ck({charge_pump_en_o, status_gate_ov_o, fault_pin}, 3'h5);
      cmd(gdfh_pkg::gdfh_oc_report, 2'h0, 1'b0, 1'b0);
      overtemp_gate_shutdown_i = 1'b1;
      cyc(1);
      cmd(2'h2, 2'h0, 1'b0, 1'b1);
      overtemp_gate_shutdown_i = 1'b0;
      cyc(3);
      ck({charge_pump_en_o, gate_out_o, fault_pin, warn_pin,
          status_otsd_o}, 10'h001);
      ck({overcurrent_policy_o, warn_sel_o}, 4'h8);
      cmd(2'h2, 2'h0, 1'b0, 1'b1);
      cyc(2);
      ck({charge_pump_en_o, gate_out_o, status_otsd_o}, 8'hfe);
      oc_detect_i = 6'h08;
      cyc(1);
      oc_detect_i = 6'h00;
      digital_supply_undervoltage_i = 1'b1;
      cyc(3);
      ck({gate_out_o, fault_pin, status_oc_o, status_fault_o}, 14'h0010);
      digital_supply_undervoltage_i = 1'b0;
      cyc(3);
      ck({fault_pin, status_oc_o}, 7'h40);
      tally_and_finish();
   end
endmodule : test_gate_driver_fault_handler
`default_nettype wire
